// file: src/lfs_pkg.sv
/*
 * constants, types and register map of the led flash trigger sequencer.
 * assumes one 10 MHz clock and an apb master with 32-bit data.
 */
package lfs_pkg;
    // ==========================================================
    // bus geometry
    localparam int DATA_W = 32; // apb data width
    localparam int ADDR_W = 8; // byte address width seen by the block

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00; // mode, edge, run mode, steady level
    localparam logic [7:0] ADDR_CMD = 8'h04; // write-only software trigger
    localparam logic [7:0] ADDR_CURRENT = 8'h08; // led current setpoint
    localparam logic [7:0] ADDR_LED_DLY = 8'h0c; // trigger to led pulse, 20 ns units
    localparam logic [7:0] ADDR_LED_WID = 8'h10; // led pulse length, 20 ns units
    localparam logic [7:0] ADDR_CAM_DLY = 8'h14; // trigger to camera pulse
    localparam logic [7:0] ADDR_CAM_WID = 8'h18; // camera pulse length
    localparam logic [7:0] ADDR_PERIOD = 8'h1c; // least spacing of sequence steps
    localparam logic [7:0] ADDR_SEQ_LEN = 8'h20; // index of the last step
    localparam logic [7:0] ADDR_STATUS = 8'h24; // busy, step, outputs
    localparam logic [7:0] ADDR_SEG_BASE = 8'h40; // 16 words of segment masks

    // ==========================================================
    // field positions
    localparam int CTRL_MODE_LSB = 0; // two-bit mode field
    localparam int CTRL_EDGE_BIT = 2; // 1 selects the falling edge
    localparam int CTRL_STEP_BIT = 3; // 1 selects one step per trigger
    localparam int CTRL_ON_BIT = 4; // steady level
    localparam int CMD_GO_BIT = 0; // start or advance
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_STEP_LSB = 4;
    localparam int STAT_LED_BIT = 8;
    localparam int STAT_CAM_BIT = 9;

    // ==========================================================
    // widths and sizes
    localparam int CUR_W = 14; // current setpoint width
    localparam int SEG_W = 4; // led segments
    localparam int NUM_STEPS = 16; // steps per sequence
    localparam int STEP_W = 4; // step index width
    localparam int TIME_W = 32; // programmed time width
    localparam int ET_W = 34; // elapsed time, room for sums

    // ==========================================================
    // time base
    localparam int TICK_NS = 20; // programming granularity
    localparam int CLK_NS = 100; // pclk period
    localparam int UNITS_PER_CLK = CLK_NS / TICK_NS; // units added per cycle
    localparam int MIN_WIDTH_NS = 1000; // shortest led pulse
    localparam int MIN_WIDTH_UNITS = (MIN_WIDTH_NS + TICK_NS - 1) / TICK_NS;
    localparam longint MAX_WIDTH_S = 85; // longest led pulse in seconds
    localparam longint MAX_WIDTH_UNITS = MAX_WIDTH_S * 64'd1000000000 / TICK_NS;

    // ==========================================================
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [13:0] CURRENT_RST = 14'h0000;
    localparam logic [31:0] LED_DLY_RST = 32'h0000_0002;
    localparam logic [31:0] LED_WID_RST = 32'h0000_0032;
    localparam logic [31:0] CAM_DLY_RST = 32'h0000_0002;
    localparam logic [31:0] CAM_WID_RST = 32'h0000_0032;
    localparam logic [31:0] PERIOD_RST = 32'h0000_0064;
    localparam logic [3:0] SEQ_LEN_RST = 4'h0;
    localparam logic [3:0] SEG_RST = 4'hf;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        LFS_MODE_STEADY = 2'b00,
        LFS_MODE_FLASH = 2'b01,
        LFS_MODE_SEQ = 2'b10
    } lfs_mode_t;

    typedef enum logic {
        LFS_ST_IDLE = 1'b0,
        LFS_ST_RUN = 1'b1
    } lfs_state_t;
endpackage : lfs_pkg

// file: src/lfs_time_base.sv
/*
 * elapsed-time counter in 20 ns units for one pulse step.
 * assumes start and run come from the sequencer in the same clock domain.
 */
module lfs_time_base (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic start,
    input wire logic run,
    output logic [lfs_pkg::ET_W-1:0] elapsed
);
    // ==========================================================
    // counter
    localparam logic [lfs_pkg::ET_W-1:0] STEP_UNITS = lfs_pkg::ET_W'(lfs_pkg::UNITS_PER_CLK);
    localparam logic [lfs_pkg::ET_W-1:0] TOP = {lfs_pkg::ET_W{1'b1}} - STEP_UNITS;

    logic [lfs_pkg::ET_W-1:0] elapsed_r; // time since start of step

    // start clears, run advances; saturation keeps long steps from wrapping
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            elapsed_r <= '0;
        end else if (ce) begin
            if (start) begin
                elapsed_r <= '0;
            end else if (run && elapsed_r <= TOP) begin
                elapsed_r <= elapsed_r + STEP_UNITS;
            end
        end
    end

    assign elapsed = elapsed_r;
endmodule : lfs_time_base

// file: src/lfs_sequencer.sv
/*
 * led flash trigger sequencer: trigger edge detect, pulse timing,
 * camera trigger, 16-step segment sequence, apb register slave.
 * assumes trig_in is already synchronous to pclk and a zero-wait apb master.
 */
// The implementer's own choices: the address map and register access over APB.
// Operation
// - trigger edge polarity selectable
// - timing values in 20 ns units
// - led pulse width 1 us to 85 s
// - steady mode holds led on or off
// - current setpoint is 14 bits
// - camera trigger pulse with each flash
// - sequence holds one to sixteen steps
// - each step has its own segments
// - automatic mode runs whole sequence
// - single step mode advances one step
// - software command replaces trigger edge
module lfs_sequencer #(
    parameter longint MAX_WIDTH_UNITS = lfs_pkg::MAX_WIDTH_UNITS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [lfs_pkg::ADDR_W-1:0] paddr,
    input wire logic [lfs_pkg::DATA_W-1:0] pwdata,
    output logic [lfs_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trig_in,
    output logic led_on_o,
    output logic [lfs_pkg::SEG_W-1:0] led_seg_o,
    output logic [lfs_pkg::CUR_W-1:0] led_cur_o,
    output logic cam_trig_o,
    output logic busy_o
);
    // ==========================================================
    // helpers
    function automatic logic in_window(input logic [lfs_pkg::ET_W-1:0] t,
                                       input logic [lfs_pkg::ET_W-1:0] from,
                                       input logic [lfs_pkg::ET_W-1:0] to);
        in_window = (t >= from) && (t < to);
    endfunction : in_window

    function automatic logic [lfs_pkg::ET_W-1:0] ext(input logic [lfs_pkg::TIME_W-1:0] v);
        ext = lfs_pkg::ET_W'(v);
    endfunction : ext

    // ==========================================================
    // registers
    logic [1:0] mode_r; // operating mode field
    logic edge_fall_r; // 1: high-to-low is active
    logic stepwise_r; // 1: one step per trigger
    logic steady_on_r; // steady level
    logic [lfs_pkg::CUR_W-1:0] cur_r; // current setpoint
    logic [lfs_pkg::TIME_W-1:0] led_dly_r; // led delay
    logic [lfs_pkg::TIME_W-1:0] led_wid_r; // led width as written
    logic [lfs_pkg::TIME_W-1:0] cam_dly_r; // camera delay
    logic [lfs_pkg::TIME_W-1:0] cam_wid_r; // camera width
    logic [lfs_pkg::TIME_W-1:0] period_r; // step spacing
    logic [lfs_pkg::STEP_W-1:0] last_r; // last step index
    logic [lfs_pkg::SEG_W-1:0] seg_r [lfs_pkg::NUM_STEPS]; // per-step segments
    logic soft_go_r; // software trigger pulse

    lfs_pkg::lfs_state_t state_r; // idle or running a step
    logic [lfs_pkg::STEP_W-1:0] step_r; // current step index
    logic trig_prev_r; // trigger input one cycle ago
    logic led_on_r;
    logic cam_trig_r;
    logic [lfs_pkg::SEG_W-1:0] led_seg_r;

    // ==========================================================
    // apb decode
    logic wr_en; // write takes effect this edge
    logic seg_hit; // word-aligned address at or above the segment base; 0x80 and up alias the table
    logic [lfs_pkg::STEP_W-1:0] seg_idx; // table index from address
    logic mapped; // address belongs to a register

    assign wr_en = psel && penable && pwrite;
    assign seg_hit = paddr >= lfs_pkg::ADDR_SEG_BASE && paddr[1:0] == 2'b00;
    assign seg_idx = paddr[2 +: lfs_pkg::STEP_W];
    assign mapped = seg_hit || (paddr[1:0] == 2'b00 && paddr <= lfs_pkg::ADDR_STATUS);
    // zero wait states keep the slave simple; every access ends in its access cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // control register; the illegal mode code is read back as written but acts as steady
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= lfs_pkg::CTRL_RST[lfs_pkg::CTRL_MODE_LSB +: 2];
            edge_fall_r <= lfs_pkg::CTRL_RST[lfs_pkg::CTRL_EDGE_BIT];
            stepwise_r <= lfs_pkg::CTRL_RST[lfs_pkg::CTRL_STEP_BIT];
            steady_on_r <= lfs_pkg::CTRL_RST[lfs_pkg::CTRL_ON_BIT];
        end else if (ce && wr_en && paddr == lfs_pkg::ADDR_CTRL) begin
            mode_r <= pwdata[lfs_pkg::CTRL_MODE_LSB +: 2];
            edge_fall_r <= pwdata[lfs_pkg::CTRL_EDGE_BIT];
            stepwise_r <= pwdata[lfs_pkg::CTRL_STEP_BIT];
            steady_on_r <= pwdata[lfs_pkg::CTRL_ON_BIT];
        end
    end

    // current, length and timing registers; the times are counted in 20 ns units
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_r <= lfs_pkg::CURRENT_RST;
            led_dly_r <= lfs_pkg::LED_DLY_RST;
            led_wid_r <= lfs_pkg::LED_WID_RST;
            cam_dly_r <= lfs_pkg::CAM_DLY_RST;
            cam_wid_r <= lfs_pkg::CAM_WID_RST;
            period_r <= lfs_pkg::PERIOD_RST;
            last_r <= lfs_pkg::SEQ_LEN_RST;
        end else if (ce && wr_en) begin
            unique case (paddr)
                lfs_pkg::ADDR_CURRENT: cur_r <= pwdata[lfs_pkg::CUR_W-1:0];
                lfs_pkg::ADDR_LED_DLY: led_dly_r <= pwdata;
                lfs_pkg::ADDR_LED_WID: led_wid_r <= pwdata;
                lfs_pkg::ADDR_CAM_DLY: cam_dly_r <= pwdata;
                lfs_pkg::ADDR_CAM_WID: cam_wid_r <= pwdata;
                lfs_pkg::ADDR_PERIOD: period_r <= pwdata;
                lfs_pkg::ADDR_SEQ_LEN: last_r <= pwdata[lfs_pkg::STEP_W-1:0];
                default: ; // other offsets are handled elsewhere or unmapped
            endcase
        end
    end

    // segment table, one mask per step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < lfs_pkg::NUM_STEPS; i++) begin
                seg_r[i] <= lfs_pkg::SEG_RST;
            end
        end else if (ce && wr_en && seg_hit) begin
            seg_r[seg_idx] <= pwdata[lfs_pkg::SEG_W-1:0];
        end
    end

    // software trigger: a write of the go bit becomes one pulse next cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_go_r <= 1'b0;
        end else if (ce) begin
            soft_go_r <= wr_en && paddr == lfs_pkg::ADDR_CMD && pwdata[lfs_pkg::CMD_GO_BIT];
        end
    end

    // read mux; write-only and reserved bits read as zero
    always_comb begin
        prdata = '0;
        if (seg_hit) begin
            prdata[lfs_pkg::SEG_W-1:0] = seg_r[seg_idx];
        end else begin
            unique case (paddr)
                lfs_pkg::ADDR_CTRL: begin
                    prdata[lfs_pkg::CTRL_MODE_LSB +: 2] = mode_r;
                    prdata[lfs_pkg::CTRL_EDGE_BIT] = edge_fall_r;
                    prdata[lfs_pkg::CTRL_STEP_BIT] = stepwise_r;
                    prdata[lfs_pkg::CTRL_ON_BIT] = steady_on_r;
                end
                lfs_pkg::ADDR_CURRENT: prdata[lfs_pkg::CUR_W-1:0] = cur_r;
                lfs_pkg::ADDR_LED_DLY: prdata = led_dly_r;
                lfs_pkg::ADDR_LED_WID: prdata = led_wid_r;
                lfs_pkg::ADDR_CAM_DLY: prdata = cam_dly_r;
                lfs_pkg::ADDR_CAM_WID: prdata = cam_wid_r;
                lfs_pkg::ADDR_PERIOD: prdata = period_r;
                lfs_pkg::ADDR_SEQ_LEN: prdata[lfs_pkg::STEP_W-1:0] = last_r;
                lfs_pkg::ADDR_STATUS: begin
                    prdata[lfs_pkg::STAT_BUSY_BIT] = state_r == lfs_pkg::LFS_ST_RUN;
                    prdata[lfs_pkg::STAT_STEP_LSB +: lfs_pkg::STEP_W] = step_r;
                    prdata[lfs_pkg::STAT_LED_BIT] = led_on_r;
                    prdata[lfs_pkg::STAT_CAM_BIT] = cam_trig_r;
                end
                default: prdata = '0; // command and unmapped offsets
            endcase
        end
    end

    // ==========================================================
    // trigger detect
    logic trig_edge; // active edge seen this cycle
    logic pulsed; // flash or sequence mode
    logic go; // accepted start or advance

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_prev_r <= 1'b0;
        end else if (ce) begin
            trig_prev_r <= trig_in;
        end
    end

    assign trig_edge = edge_fall_r ? (trig_prev_r && !trig_in) : (!trig_prev_r && trig_in);
    assign pulsed = mode_r == lfs_pkg::LFS_MODE_FLASH || mode_r == lfs_pkg::LFS_MODE_SEQ;
    // edges during a running step fall through: there is no queue of pending triggers
    assign go = pulsed && state_r == lfs_pkg::LFS_ST_IDLE && (trig_edge || soft_go_r);

    // ==========================================================
    // step timing
    logic [lfs_pkg::ET_W-1:0] elapsed; // time since step start
    logic [lfs_pkg::TIME_W-1:0] led_wid_c; // width clamped to legal range
    logic [lfs_pkg::ET_W-1:0] led_off_at; // end of led pulse
    logic [lfs_pkg::ET_W-1:0] cam_off_at; // end of camera pulse
    logic step_end; // current step complete
    logic tb_start; // restart the time base
    logic is_seq; // sequence mode
    logic at_last; // current step is the last one

    lfs_time_base u_time_base (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .start(tb_start),
        .run(state_r == lfs_pkg::LFS_ST_RUN),
        .elapsed(elapsed)
    );

    // clamping costs two comparators but keeps a zero or huge width from hanging the led on
    always_comb begin
        led_wid_c = led_wid_r;
        if (led_wid_r < lfs_pkg::TIME_W'(lfs_pkg::MIN_WIDTH_UNITS)) begin
            led_wid_c = lfs_pkg::TIME_W'(lfs_pkg::MIN_WIDTH_UNITS);
        end else if (ext(led_wid_r) > lfs_pkg::ET_W'(MAX_WIDTH_UNITS)) begin
            led_wid_c = lfs_pkg::TIME_W'(MAX_WIDTH_UNITS);
        end
    end

    assign led_off_at = ext(led_dly_r) + ext(led_wid_c);
    assign cam_off_at = ext(cam_dly_r) + ext(cam_wid_r);
    // a step lasts until both pulses ended and the period has passed
    assign step_end = state_r == lfs_pkg::LFS_ST_RUN && elapsed >= led_off_at
        && elapsed >= cam_off_at && elapsed >= ext(period_r);
    assign is_seq = mode_r == lfs_pkg::LFS_MODE_SEQ;
    assign at_last = step_r >= last_r;
    assign tb_start = go || (step_end && is_seq && !stepwise_r && !at_last);

    // ==========================================================
    // sequencer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= lfs_pkg::LFS_ST_IDLE;
        end else if (ce) begin
            unique case (state_r)
                lfs_pkg::LFS_ST_IDLE: begin
                    if (go) begin
                        state_r <= lfs_pkg::LFS_ST_RUN;
                    end
                end
                lfs_pkg::LFS_ST_RUN: begin
                    if (!pulsed) begin
                        state_r <= lfs_pkg::LFS_ST_IDLE;
                    end else if (step_end && !(is_seq && !stepwise_r && !at_last)) begin
                        state_r <= lfs_pkg::LFS_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // step index; moves at the end of a step, wraps after the last
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_r <= '0;
        end else if (ce) begin
            if (!is_seq) begin
                step_r <= '0;
            end else if (step_end) begin
                if (at_last) begin
                    step_r <= '0;
                end else begin
                    step_r <= step_r + 4'h1;
                end
            end
        end
    end

    // ==========================================================
    // outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led_on_r <= 1'b0;
            cam_trig_r <= 1'b0;
            led_seg_r <= '0;
        end else if (ce) begin
            if (!pulsed) begin
                led_on_r <= steady_on_r;
                cam_trig_r <= 1'b0;
                led_seg_r <= seg_r[0];
            end else begin
                led_on_r <= state_r == lfs_pkg::LFS_ST_RUN
                    && in_window(elapsed, ext(led_dly_r), led_off_at);
                cam_trig_r <= state_r == lfs_pkg::LFS_ST_RUN
                    && in_window(elapsed, ext(cam_dly_r), cam_off_at);
                led_seg_r <= seg_r[step_r];
            end
        end
    end

    assign led_on_o = led_on_r;
    assign cam_trig_o = cam_trig_r;
    assign led_seg_o = led_seg_r;
    assign led_cur_o = cur_r;
    assign busy_o = state_r == lfs_pkg::LFS_ST_RUN;

    // ==========================================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_idle_pulsed;
        ce && state_r == lfs_pkg::LFS_ST_IDLE && pulsed;
    endsequence

    sequence s_auto_mid;
        ce && step_end && is_seq && !stepwise_r && !at_last;
    endsequence

    a_rise_start: assert property (
        (s_idle_pulsed and (!edge_fall_r && !trig_prev_r && trig_in))
        |=> state_r == lfs_pkg::LFS_ST_RUN) else $error("rising edge did not start");
    a_fall_start: assert property (
        (s_idle_pulsed and (edge_fall_r && trig_prev_r && !trig_in))
        |=> state_r == lfs_pkg::LFS_ST_RUN) else $error("falling edge did not start");
    a_tick_units: assert property (
        ce && state_r == lfs_pkg::LFS_ST_RUN && !tb_start && elapsed < 34'h0_ffff_0000
        |=> elapsed == $past(elapsed) + 34'h5) else $error("time base not in 20 ns units");
    a_steady_level: assert property (
        ce && mode_r == lfs_pkg::LFS_MODE_STEADY
        |=> led_on_o == $past(steady_on_r) && !cam_trig_o) else $error("steady level wrong");
    a_flash_gated: assert property (
        (led_on_o || cam_trig_o) && $past(pulsed)
        |-> $past(state_r) == lfs_pkg::LFS_ST_RUN) else $error("pulse outside a step");
    a_seg_follow: assert property (
        ce && is_seq ##1 ce
        |-> led_seg_o == $past(seg_r[step_r])) else $error("segments not from step");
    a_auto_next: assert property (
        s_auto_mid
        |=> state_r == lfs_pkg::LFS_ST_RUN && step_r == $past(step_r) + 4'h1)
        else $error("automatic mode stopped");
    a_single_step: assert property (
        ce && step_end && is_seq && stepwise_r && !at_last && pulsed
        |=> state_r == lfs_pkg::LFS_ST_IDLE && step_r == $past(step_r) + 4'h1)
        else $error("single step wrong");
    a_soft_start: assert property (
        (s_idle_pulsed and soft_go_r)
        |=> state_r == lfs_pkg::LFS_ST_RUN) else $error("software go ignored");
    a_busy_ignore: assert property (
        ce && state_r == lfs_pkg::LFS_ST_RUN && !step_end && pulsed
        |=> state_r == lfs_pkg::LFS_ST_RUN && $stable(step_r)) else $error("edge while busy");
    a_wrap_first: assert property (
        ce && step_end && is_seq && at_last
        |=> step_r == 4'h0 ##0 state_r == lfs_pkg::LFS_ST_IDLE)
        else $error("no wrap to first step");
endmodule : lfs_sequencer

// file: test/lfs_far_end.sv
/*
 * far-side model: trigger source and triggered camera.
 * assumes the tb calls edge_to and reads the camera counters.
 */
module lfs_far_end (
    input wire logic pclk,
    output logic trig_line,
    input wire logic cam_line,
    output int cam_pulses,
    output int cam_cycles
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // trigger source
    logic cam_q = 1'b0; // last camera level
    initial begin
        trig_line = 1'b0;
        cam_pulses = 0;
        cam_cycles = 0;
    end
    // new level just after an edge, held two cycles so it is surely sampled
    task automatic edge_to(input logic v);
        @(posedge pclk);
        trig_line <= v;
        repeat (2) @(posedge pclk);
    endtask : edge_to
    // ==========================================================
    // camera: count pulses and high cycles
    always @(posedge pclk) begin
        cam_q <= cam_line;
        if (cam_line) cam_cycles <= cam_cycles + 1;
        if (cam_line && !cam_q) cam_pulses <= cam_pulses + 1;
    end
endmodule : lfs_far_end

// file: test/tb.sv
/*
 * self-checking bench of the flash sequencer over apb.
 * assumes zero-wait apb and a 200-unit width cap set by parameter.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // signals
    logic pclk, presetn, ce, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, trig_in, led_on_o, cam_trig_o, busy_o, err, led_q = 0;
    logic [3:0] led_seg_o;
    logic [13:0] led_cur_o;
    logic [15:0] seg_log = 16'h0; // masks seen at each led rise
    int err_count = 0, compares = 0, rises = 0, wid = 0, cams, cam_hi, w0, r0, c0, h0;
    lfs_sequencer #(.MAX_WIDTH_UNITS(200)) lfs_sequencer_i (.pclk(pclk), .presetn(presetn),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trig_in(trig_in), .led_on_o(led_on_o), .led_seg_o(led_seg_o),
        .led_cur_o(led_cur_o), .cam_trig_o(cam_trig_o), .busy_o(busy_o));
    lfs_far_end lfs_far_end_i (.pclk(pclk), .trig_line(trig_in), .cam_line(cam_trig_o),
        .cam_pulses(cams), .cam_cycles(cam_hi));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // ==========================================================
    // led monitor: high cycles, rises, segment log
    always @(posedge pclk) begin
        led_q <= led_on_o;
        if (led_on_o) wid <= wid + 1;
        if (led_on_o && !led_q) begin
            rises <= rises + 1;
            seg_log <= {seg_log[11:0], led_seg_o};
        end
    end
    // ==========================================================
    // tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one apb transfer; waits on pready, never on a fixed count
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // idle means busy low three cycles running, so gaps between steps are not mistaken
    task automatic settle;
        int q;
        q = 0;
        repeat (2) @(posedge pclk);
        while (q < 3) begin
            @(posedge pclk);
            q = (busy_o === 1'b0) ? q + 1 : 0;
        end
    endtask : settle
    // one flash of width w units; led high while elapsed (steps of 5) in [2, 2+clamped w)
    task automatic flash(input int w);
        int c;
        c = (w < 50) ? 50 : ((w > 200) ? 200 : w);
        xfer(1, lfs_pkg::ADDR_LED_WID, w);
        w0 = wid;
        c0 = cams;
        h0 = cam_hi;
        lfs_far_end_i.edge_to(1'b0);
        lfs_far_end_i.edge_to(1'b1);
        settle;
        chk("led width", (c + 1) / 5, wid - w0);
        chk("cam pulses", 1, cams - c0);
        chk("cam width", 10, cam_hi - h0);
    endtask : flash
    task automatic report_and_stop;
        if (err_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    // ==========================================================
    // tests
    initial begin
        presetn <= 1'b0;
        ce <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        xfer(0, lfs_pkg::ADDR_LED_WID, 0);
        chk("wid reset", 32'h32, rd);
        xfer(0, lfs_pkg::ADDR_SEG_BASE, 0);
        chk("seg reset", 32'hf, rd);
        xfer(1, 8'h28, 32'h1);
        chk("unmapped err", 1, err);
        xfer(1, lfs_pkg::ADDR_CURRENT, 32'hffff_ffff);
        @(posedge pclk);
        chk("current", 32'h3fff, led_cur_o);
        xfer(1, lfs_pkg::ADDR_CTRL, 32'h10);
        repeat (2) @(posedge pclk);
        chk("steady on", 1, led_on_o);
        xfer(1, lfs_pkg::ADDR_CTRL, 32'h0);
        repeat (2) @(posedge pclk);
        chk("steady off", 0, led_on_o);
        // clock enable low: the write below must be lost and the led stay off
        ce <= 1'b0;
        xfer(1, lfs_pkg::ADDR_CTRL, 32'h10);
        ce <= 1'b1;
        xfer(0, lfs_pkg::ADDR_CTRL, 0);
        chk("ctrl frozen", 32'h0, rd);
        chk("led frozen", 0, led_on_o);
        // the unused mode code behaves as steady
        xfer(1, lfs_pkg::ADDR_CTRL, 32'h13);
        repeat (2) @(posedge pclk);
        chk("mode 3 steady", 1, led_on_o);
        xfer(1, lfs_pkg::ADDR_CTRL, 32'h1);
        flash(1);
        flash(100);
        flash(1000);
        xfer(1, lfs_pkg::ADDR_LED_WID, 50);
        xfer(1, lfs_pkg::ADDR_CTRL, 32'h5);
        r0 = rises;
        lfs_far_end_i.edge_to(1'b0);
        settle;
        chk("fall taken", r0 + 1, rises);
        lfs_far_end_i.edge_to(1'b1);
        settle;
        chk("rise ignored", r0 + 1, rises);
        for (int i = 0; i < 3; i++) xfer(1, lfs_pkg::ADDR_SEG_BASE + 8'(4 * i), 1 << i);
        xfer(1, lfs_pkg::ADDR_SEQ_LEN, 2);
        xfer(1, lfs_pkg::ADDR_CTRL, 32'h2);
        r0 = rises;
        c0 = cams;
        lfs_far_end_i.edge_to(1'b0);
        lfs_far_end_i.edge_to(1'b1);
        lfs_far_end_i.edge_to(1'b0);
        lfs_far_end_i.edge_to(1'b1); // second edge lands mid-sequence
        settle;
        chk("auto steps", r0 + 3, rises);
        chk("auto cams", c0 + 3, cams);
        chk("auto segs", 32'h124, seg_log[11:0]);
        xfer(1, lfs_pkg::ADDR_CTRL, 32'ha);
        lfs_far_end_i.edge_to(1'b0);
        lfs_far_end_i.edge_to(1'b1);
        settle;
        for (int i = 0; i < 2; i++) begin
            xfer(1, lfs_pkg::ADDR_CMD, 32'h1);
            settle;
        end
        lfs_far_end_i.edge_to(1'b0);
        lfs_far_end_i.edge_to(1'b1);
        settle;
        chk("step segs", 32'h1241, seg_log);
        report_and_stop;
    end
    // watchdog: whole run is a few hundred cycles
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        report_and_stop;
    end
endmodule : tb
